//--- verilog/sfslw_bank.sv
// fault-status register bank, frame decode and link watchdog
`timescale 1ns/1ps
//
// Contract
// (R1) time gap since last valid frame; disruption when it exceeds programmed threshold
// (R2) on disruption hold last output state or tri-state all four outputs
// (R3) fault pin low while disruption is present
// (R4) fault pin returns high by itself once valid frames resume
// (R5) disruption flag latches at primary bit 16, host clears with a one
// (R6) control-source strap low picks direct inputs, high picks serial commands
// (R7) primary bits 31 and 30 follow the two control-source straps
// (R8) primary bit 29 follows the output-topology straps, no latch
// (R9) primary bits 27..22 diagnosis pairs, bits 21..20 channel diagnosis results
// (R10) bit 19 overtemperature self-clearing; bits 18,17 idle open-load per channel
// (R11) bits 15,14,13 latch crc, clock-count and address errors; write one clears
// (R12) bit 12 latches reference clock fault until written with one
// (R13) bit 11 battery undervoltage live; bit 10 logic undervoltage latched
// (R14) bits 9,8 channel fault state live, set on detecting channel
// (R15) channel word bits 27..26 overcurrent pair, 23..20 open-load pairs
// (R16) channel bits 19..16 per-output overcurrent, bit 15 running open-load, live
// (R17) channel 2 word mirrors channel 1 layout
// (R18) latched flags clear only on written one; zero leaves them
// (R19) threshold and reaction come from first configuration word, shared
// (R20) frame: rw bit 39, address 38:32, data 31:8, crc 7:0
module sfslw_bank
  import sfslw_pkg::*;
#(
  parameter int WDT_STEP_CYCLES = WDT_STEP_CYC
) (
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_mosi_in,
  output logic             spi_miso_out,
  output logic             spi_miso_oe_out,
  input  wire logic        crc_mismatch_in,
  input  wire logic        ch1_control_source_strap_in,
  input  wire logic        ch2_control_source_strap_in,
  input  wire logic        ch1_output_topology_strap_in,
  input  wire logic        ch2_output_topology_strap_in,
  input  wire logic [5:0]  init_fault_output_pin_pairs_in,
  input  wire logic [1:0]  init_fault_output_pin_result_in,
  input  wire logic        overtemp_in,
  input  wire logic [1:0]  open_load_idle_in,
  input  wire logic        vbat_uv_in,
  input  wire logic        vcc_uv_in,
  input  wire logic        ext_clk_fault_in,
  input  wire logic [1:0]  chan_fault_in,
  input  wire logic [10:0] ch1_status_in,
  input  wire logic [10:0] ch2_status_in,
  output logic             fault_output_pin_out,
  output logic             bridge_hold_out,
  output logic             bridge_hiz_out,
  output logic             ch1_spi_drive_out,
  output logic             ch2_spi_drive_out
);

  // ==========================================================
  // pin synchronisers
  logic [1:0] cs_sync;
  logic [1:0] sclk_sync;
  logic [1:0] mosi_sync;
  logic [1:0] strap1_sync;
  logic [1:0] strap2_sync;
  logic [1:0] topo1_sync;
  logic [1:0] topo2_sync;
  logic       cs_d;
  logic       sclk_d;

  always_ff @(posedge sys_clk_in) begin
    cs_sync     <= {cs_sync[0], spi_cs_n_in};
    sclk_sync   <= {sclk_sync[0], spi_sclk_in};
    mosi_sync   <= {mosi_sync[0], spi_mosi_in};
    strap1_sync <= {strap1_sync[0], ch1_control_source_strap_in};
    strap2_sync <= {strap2_sync[0], ch2_control_source_strap_in};
    topo1_sync  <= {topo1_sync[0], ch1_output_topology_strap_in};
    topo2_sync  <= {topo2_sync[0], ch2_output_topology_strap_in};
    cs_d        <= cs_sync[1];
    sclk_d      <= sclk_sync[1];
  end

  logic cs_low;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  assign cs_low      = ~cs_sync[1];
  assign sclk_rise   = sclk_sync[1] & ~sclk_d;
  assign sclk_fall   = ~sclk_sync[1] & sclk_d;
  assign frame_start = ~cs_sync[1] & cs_d;
  assign frame_end   = cs_sync[1] & ~cs_d;

  // ==========================================================
  // frame decode
  logic [39:0] rx_shift;
  logic [5:0]  bit_cnt;
  logic [6:0]  rx_addr;
  logic [23:0] rx_data;
  logic        cnt_bad;
  logic        addr_bad;
  logic        frame_ok;
  logic        wr_ok;

  assign rx_addr  = rx_shift[ADDR_MSB:ADDR_LSB]; // R20
  assign rx_data  = rx_shift[DATA_MSB:DATA_LSB]; // R20
  assign cnt_bad  = bit_cnt != 6'(FRAME_BITS);
  assign addr_bad = rx_addr > ADDR_MAX;
  // crc checker output is only meaningful at the close of the frame
  assign frame_ok = frame_end & ~cnt_bad & ~crc_mismatch_in & ~addr_bad;
  assign wr_ok    = frame_ok & rx_shift[RW_POS]; // R20

  // ==========================================================
  // status words
  logic [23:0] latched;
  logic [23:0] cfg1;
  logic [23:0] primary_word;
  logic [23:0] ch1_word;
  logic [23:0] ch2_word;
  logic [23:0] read_word;

  function automatic logic [23:0] chan_word(input logic [10:0] s);
    logic [23:0] w;
    w = 24'h00_0000;
    w[C_OCPAIR_LO +: 2] = s[10:9]; // R15
    w[C_OLPAIR_LO +: 4] = s[8:5];  // R15
    w[C_SHORT_LO +: 4]  = s[4:1];  // R16
    w[C_OLRUN]          = s[0];    // R16
    return w;
  endfunction

  always_comb begin
    primary_word = latched;
    primary_word[P_STRAP1]        = strap1_sync[1]; // R7
    primary_word[P_STRAP2]        = strap2_sync[1]; // R7
    primary_word[P_TOPO]          = topo1_sync[1] | topo2_sync[1]; // R8
    primary_word[P_DPAIR_LO +: 6] = init_fault_output_pin_pairs_in; // R9
    primary_word[P_DRES_LO +: 2]  = init_fault_output_pin_result_in; // R9
    primary_word[P_OTEMP]         = overtemp_in; // R10
    primary_word[P_OLIDLE1]       = open_load_idle_in[0]; // R10
    primary_word[P_OLIDLE2]       = open_load_idle_in[1]; // R10
    primary_word[P_VBAT]          = vbat_uv_in; // R13
    primary_word[P_CH1STATE]      = chan_fault_in[0]; // R14
    primary_word[P_CH2STATE]      = chan_fault_in[1]; // R14
  end

  assign ch1_word = chan_word(ch1_status_in); // R16
  assign ch2_word = chan_word(ch2_status_in); // R17

  always_comb begin
    case (rx_addr)
      ADDR_PRIMARY: read_word = primary_word;
      ADDR_CH1:     read_word = ch1_word;
      ADDR_CH2:     read_word = ch2_word;
      ADDR_CFG1:    read_word = cfg1;
      default:      read_word = 24'h00_0000;
    endcase
  end

  // ==========================================================
  // serial shifter; answer to frame n goes out during frame n+1
  logic [39:0] tx_shift;
  logic [39:0] next_rx_shift;
  logic [5:0]  next_bit_cnt;
  logic [39:0] next_tx_shift;
  logic        next_miso;

  always_comb begin
    next_rx_shift = rx_shift;
    next_bit_cnt  = bit_cnt;
    next_tx_shift = tx_shift;
    next_miso     = spi_miso_out;
    if (frame_start) begin
      next_bit_cnt = 6'h00;
      next_miso    = tx_shift[39];
    end
    if (cs_low && sclk_rise) begin
      next_rx_shift = {rx_shift[38:0], mosi_sync[1]};
      // saturates so an overlong frame is still seen as a count error
      if (bit_cnt != 6'h3F) begin
        next_bit_cnt = bit_cnt + 6'h01;
      end
    end
    if (cs_low && sclk_fall) begin
      next_tx_shift = {tx_shift[38:0], 1'b0};
      next_miso     = tx_shift[38];
    end
    if (frame_end) begin
      next_tx_shift = {rx_shift[39:32], read_word, RSP_CRC_FILL};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rx_shift        <= 40'h00_0000_0000;
      bit_cnt         <= 6'h00;
      tx_shift        <= 40'h00_0000_0000;
      spi_miso_out    <= 1'b0;
      spi_miso_oe_out <= 1'b0;
    end else begin
      rx_shift        <= next_rx_shift;
      bit_cnt         <= next_bit_cnt;
      tx_shift        <= next_tx_shift;
      spi_miso_out    <= next_miso;
      spi_miso_oe_out <= cs_low;
    end
  end

  // ==========================================================
  // latched flags and configuration
  logic        disrupt;
  logic [23:0] set_vec;
  logic [23:0] clr_vec;
  logic [23:0] next_latched;
  logic [23:0] next_cfg1;

  always_comb begin
    set_vec            = 24'h00_0000;
    set_vec[P_LINK]    = disrupt; // R5
    set_vec[P_CRC]     = frame_end & crc_mismatch_in; // R11
    set_vec[P_SCLKCNT] = frame_end & cnt_bad; // R11
    set_vec[P_BADADDR] = frame_end & ~cnt_bad & addr_bad; // R11
    set_vec[P_EXTCLK]  = ext_clk_fault_in; // R12
    set_vec[P_VCC]     = vcc_uv_in; // R13
    clr_vec = 24'h00_0000;
    if (wr_ok && rx_addr == ADDR_PRIMARY) begin
      clr_vec = rx_data & W1C_MASK; // R18
    end
    // a new event in the clearing cycle survives the clear
    next_latched = ((latched & ~clr_vec) | set_vec) & W1C_MASK; // R18
    next_cfg1 = cfg1;
    if (wr_ok && rx_addr == ADDR_CFG1) begin
      next_cfg1 = rx_data; // R19
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      latched <= 24'h00_0000;
      cfg1    <= CFG1_RESET;
    end else begin
      latched <= next_latched;
      cfg1    <= next_cfg1;
    end
  end

  // ==========================================================
  // link watchdog and output reaction
  logic [WDT_W-1:0] wdt_cnt;
  logic [WDT_W-1:0] wdt_limit;
  logic [WDT_W-1:0] next_wdt_cnt;
  logic             next_disrupt;
  logic             react_hiz;

  assign react_hiz = cfg1[CFG_WDT_REACT]; // R19
  assign wdt_limit = WDT_W'(WDT_STEP_CYCLES * (32'(cfg1[CFG_WDT_TH_LO +: 2]) + 1)); // R19

  always_comb begin
    next_wdt_cnt = wdt_cnt;
    next_disrupt = disrupt;
    if (frame_ok) begin
      next_wdt_cnt = '0; // R1
      next_disrupt = 1'b0; // R4
    end else if (wdt_cnt >= wdt_limit) begin
      next_disrupt = 1'b1; // R1
    end else begin
      next_wdt_cnt = wdt_cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      wdt_cnt              <= '0;
      disrupt              <= 1'b0;
      fault_output_pin_out <= 1'b1;
      bridge_hold_out      <= 1'b0;
      bridge_hiz_out       <= 1'b0;
      ch1_spi_drive_out    <= 1'b0;
      ch2_spi_drive_out    <= 1'b0;
    end else begin
      wdt_cnt              <= next_wdt_cnt;
      disrupt              <= next_disrupt;
      fault_output_pin_out <= ~next_disrupt; // R3
      bridge_hold_out      <= next_disrupt & ~react_hiz; // R2
      bridge_hiz_out       <= next_disrupt & react_hiz; // R2
      ch1_spi_drive_out    <= strap1_sync[1]; // R6
      ch2_spi_drive_out    <= strap2_sync[1]; // R6
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_good_frame;
    frame_ok;
  endsequence
  sequence s_recovered;
    !disrupt ##0 fault_output_pin_out ##0 !bridge_hiz_out ##0 !bridge_hold_out;
  endsequence

  a_timeout_fires: assert property ( // R1
    (wdt_cnt >= wdt_limit && !frame_ok) |=> disrupt
  ) else $error("watchdog did not flag disruption at threshold");
  a_frame_rearms: assert property ( // R1
    s_good_frame |=> (wdt_cnt == '0)
  ) else $error("valid frame did not restart watchdog");
  a_hiz_reaction: assert property ( // R2
    (disrupt && react_hiz && $stable(react_hiz)) |-> (bridge_hiz_out && !bridge_hold_out)
  ) else $error("hi-z reaction not applied");
  a_fault_pin_low: assert property ( // R3
    disrupt |-> !fault_output_pin_out
  ) else $error("fault pin high during disruption");
  a_pin_recovers: assert property ( // R4
    (disrupt ##0 s_good_frame) |=> s_recovered
  ) else $error("no recovery after valid frame");
  a_link_flag_set: assert property ( // R5
    disrupt |=> latched[P_LINK] throughout (##1 1'b1)
  ) else $error("disruption flag not latched");
  a_flag_holds: assert property ( // R18
    (latched[P_LINK] && !(wr_ok && rx_addr == ADDR_PRIMARY && rx_data[P_LINK]))
      |=> latched[P_LINK]
  ) else $error("latched flag lost without written one");
  a_crc_clear: assert property ( // R11
    (wr_ok && rx_addr == ADDR_PRIMARY && rx_data[P_CRC]) |=> !latched[P_CRC]
  ) else $error("crc flag not cleared by written one");
  a_count_error: assert property ( // R11
    (frame_end && cnt_bad) |=> latched[P_SCLKCNT] ##1 latched[P_SCLKCNT]
  ) else $error("clock count error not latched");
  a_extclk_latch: assert property ( // R12
    ext_clk_fault_in |=> latched[P_EXTCLK]
  ) else $error("reference clock fault not latched");
  a_strap_select: assert property ( // R6
    $rose(ch1_control_source_strap_in) ##1 ch1_control_source_strap_in[*3]
      |=> ch1_spi_drive_out
  ) else $error("control source not following strap");
  a_cfg_capture: assert property ( // R19
    (wr_ok && rx_addr == ADDR_CFG1) |=> (cfg1 == $past(rx_data))
  ) else $error("configuration word not captured");
  a_primary_answer: assert property ( // R7
    (frame_end && rx_addr == ADDR_PRIMARY) |=> (tx_shift[31:8] == $past(primary_word))
  ) else $error("primary word answer mismatch");
  a_chan_answer: assert property ( // R17
    (frame_end && rx_addr == ADDR_CH2) |=> (tx_shift[31:8] == $past(chan_word(ch2_status_in)))
  ) else $error("channel 2 word answer mismatch");

endmodule

//--- verilog/sfslw_pkg.sv
// constants for the fault-status bank and link watchdog
package sfslw_pkg;
  // ==========================================================
  // frame layout
  localparam int FRAME_BITS   = 40;
  localparam int RW_POS       = 39;
  localparam int ADDR_MSB     = 38;
  localparam int ADDR_LSB     = 32;
  localparam int DATA_MSB     = 31;
  localparam int DATA_LSB     = 8;
  localparam logic [7:0] RSP_CRC_FILL = 8'h00;
  // ==========================================================
  // register addresses
  localparam logic [6:0] ADDR_PRIMARY = 7'h01;
  localparam logic [6:0] ADDR_CH1     = 7'h02;
  localparam logic [6:0] ADDR_CH2     = 7'h03;
  localparam logic [6:0] ADDR_CFG1    = 7'h04;
  localparam logic [6:0] ADDR_MAX     = 7'h09;
  // ==========================================================
  // primary word bit positions (data bit minus 8)
  localparam int P_STRAP1   = 23;
  localparam int P_STRAP2   = 22;
  localparam int P_TOPO     = 21;
  localparam int P_DPAIR_LO = 14;
  localparam int P_DRES_LO  = 12;
  localparam int P_OTEMP    = 11;
  localparam int P_OLIDLE1  = 10;
  localparam int P_OLIDLE2  = 9;
  localparam int P_LINK     = 8;
  localparam int P_CRC      = 7;
  localparam int P_SCLKCNT  = 6;
  localparam int P_BADADDR  = 5;
  localparam int P_EXTCLK   = 4;
  localparam int P_VBAT     = 3;
  localparam int P_VCC      = 2;
  localparam int P_CH1STATE = 1;
  localparam int P_CH2STATE = 0;
  localparam logic [23:0] W1C_MASK = 24'h00_01F4;
  // channel word bit positions
  localparam int C_OCPAIR_LO = 18;
  localparam int C_OLPAIR_LO = 12;
  localparam int C_SHORT_LO  = 8;
  localparam int C_OLRUN     = 7;
  // first configuration word fields
  localparam int CFG_WDT_TH_LO = 1;
  localparam int CFG_WDT_REACT = 0;
  // ==========================================================
  // reset values and timing
  localparam logic [23:0] CFG1_RESET = 24'h00_0000;
  localparam int CLK_MHZ      = 50;
  localparam int WDT_STEP_US  = 1000;
  localparam int WDT_STEP_CYC = WDT_STEP_US * CLK_MHZ;
  localparam int WDT_W        = 20;
endpackage

//--- sim/sfslw_host.sv
// host-side serial master model for the fault-status bank
`timescale 1ns/1ps
module sfslw_host (
  input  wire logic sys_clk_in,
  input  wire logic spi_miso_in,
  output logic      spi_cs_n_out,
  output logic      spi_sclk_out,
  output logic      spi_mosi_out
);
  // ==========================================================
  // idle levels: serial clock stands low outside frames
  initial begin
    spi_cs_n_out = 1'b1;
    spi_sclk_out = 1'b0;
    spi_mosi_out = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // ==========================================================
  // one frame, msb first, 8 system cycles per serial clock
  // short bit counts exist only to provoke count errors
  task automatic xfer(input logic [39:0] tx, input int nbits, output logic [39:0] rx);
    rx = '0;
    @(posedge sys_clk_in);
    spi_cs_n_out <= 1'b0;
    pause(4);
    for (int i = 0; i < nbits; i++) begin
      spi_mosi_out <= tx[39 - i];
      pause(4);
      spi_sclk_out <= 1'b1;
      pause(4);
      rx = {rx[38:0], spi_miso_in};
      spi_sclk_out <= 1'b0;
    end
    pause(4);
    spi_cs_n_out <= 1'b1;
    // released line flips so a stale bit never looks valid
    spi_mosi_out <= ~spi_mosi_out;
    pause(8);
  endtask
endmodule

//--- sim/sfslw_bank_bench.sv
// self-checking bench for the fault-status bank and link watchdog
`timescale 1ns/1ps
module sfslw_bank_bench
  import sfslw_pkg::*;
;
  // short watchdog step keeps the run small, frames stay well inside it
  localparam int STEP = 2000;
  logic        clk, srst, cs_n, sclk, mosi, miso, miso_oe, crc_bad;
  // released line shows the inverse, so a late or missing enable spoils the answer
  wire         miso_line = miso_oe ? miso : ~miso;
  logic        s1, s2, t1, t2, ot, vbat, vcc, extf;
  logic        fault, hold, hiz, drv1, drv2;
  logic [5:0]  pairs;
  logic [1:0]  res, oli, cf;
  logic [10:0] st1, st2;
  logic [39:0] rx;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc = 0;

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  sfslw_bank #(.WDT_STEP_CYCLES(STEP)) u_dut (
    .sys_clk_in(clk), .srst_in(srst), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
    .crc_mismatch_in(crc_bad), .ch1_control_source_strap_in(s1),
    .ch2_control_source_strap_in(s2), .ch1_output_topology_strap_in(t1),
    .ch2_output_topology_strap_in(t2), .init_fault_output_pin_pairs_in(pairs),
    .init_fault_output_pin_result_in(res), .overtemp_in(ot), .open_load_idle_in(oli),
    .vbat_uv_in(vbat), .vcc_uv_in(vcc), .ext_clk_fault_in(extf), .chan_fault_in(cf),
    .ch1_status_in(st1), .ch2_status_in(st2), .fault_output_pin_out(fault),
    .bridge_hold_out(hold), .bridge_hiz_out(hiz), .ch1_spi_drive_out(drv1),
    .ch2_spi_drive_out(drv2)
  );

  sfslw_host u_host (
    .sys_clk_in(clk), .spi_miso_in(miso_line), .spi_cs_n_out(cs_n),
    .spi_sclk_out(sclk), .spi_mosi_out(mosi)
  );

  // ==========================================================
  // reporting
  task automatic close_out;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: pin %b, want %b", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [39:0] got, input logic [6:0] a, input logic [23:0] exp);
    tests_run++;
    if (got !== {1'b0, a, exp, RSP_CRC_FILL}) begin
      n_fail++;
      $display("unexpected at %0t: frame %h, want data %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // access tasks; a read answer arrives in the following frame
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    u_host.xfer({1'b1, a, d, 8'h00}, 40, rx);
  endtask

  task automatic rd(input logic [6:0] a, input logic [23:0] exp);
    u_host.xfer({1'b0, a, 24'h00_0000, 8'h00}, 40, rx);
    u_host.xfer({1'b0, a, 24'h00_0000, 8'h00}, 40, rx);
    chk_word(rx, a, exp);
  endtask

  // primary word from the bench's own pin levels plus expected latches
  function automatic logic [23:0] pw(input logic [4:0] l, input logic lv);
    return {s1, s2, t1 | t2, 1'b0, pairs, res, ot, oli[0], oli[1], l, vbat, lv, cf[0], cf[1]};
  endfunction

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      $display("unexpected at %0t: run did not finish", $time);
      close_out();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    srst = 1'b1;
    crc_bad = 1'b0;
    {s1, s2, t1, t2, ot, vbat, vcc, extf} = 8'h00;
    pairs = 6'h2D;
    res = 2'b10;
    oli = 2'b01;
    cf = 2'b10;
    st1 = 11'h5A3;
    st2 = 11'h2C6;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    tick(2);
    chk_bit(fault, 1'b1);
    chk_bit(hold, 1'b0);
    chk_bit(miso_oe, 1'b0);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      s1 <= k[0];
      s2 <= !k[0];
      t1 <= k[0];
      t2 <= k[1];
      ot <= k[0];
      vbat <= !k[0];
      pairs <= ~pairs;
      res <= ~res;
      oli <= ~oli;
      cf <= ~cf;
      tick(6);
      chk_bit(drv1, k[0]);
      chk_bit(drv2, !k[0]);
      rd(ADDR_PRIMARY, pw(5'h00, 1'b0));
    end
    // channel words are read-only; the write must leave them alone
    wr(ADDR_CH1, 24'hFF_FFFF);
    rd(ADDR_CH1, {4'h0, st1[10:9], 2'b00, st1[8:0], 7'h00});
    rd(ADDR_CH2, {4'h0, st2[10:9], 2'b00, st2[8:0], 7'h00});
    // one-cycle causes must still be caught by the latches
    @(posedge clk);
    vcc <= 1'b1;
    extf <= 1'b1;
    @(posedge clk);
    vcc <= 1'b0;
    extf <= 1'b0;
    crc_bad <= 1'b1;
    u_host.xfer({1'b0, ADDR_CFG1, 24'h00_0000, 8'h00}, 40, rx);
    crc_bad <= 1'b0;
    u_host.xfer({1'b0, ADDR_CFG1, 24'h00_0000, 8'h00}, 39, rx);
    u_host.xfer({1'b0, 7'h7F, 24'h00_0000, 8'h00}, 40, rx);
    rd(ADDR_PRIMARY, pw(5'h0F, 1'b1));
    wr(ADDR_PRIMARY, 24'h00_0000);
    rd(ADDR_PRIMARY, pw(5'h0F, 1'b1));
    wr(ADDR_PRIMARY, 24'hFF_FFFF);
    rd(ADDR_PRIMARY, pw(5'h00, 1'b0));
    // ========================================================
    // watchdog: two steps then hold, one step then high impedance
    wr(ADDR_CFG1, 24'h00_0002);
    rd(ADDR_CFG1, 24'h00_0002);
    tick(3900);
    chk_bit(fault, 1'b1);
    tick(200);
    chk_bit(fault, 1'b0);
    chk_bit(hold, 1'b1);
    chk_bit(hiz, 1'b0);
    rd(ADDR_PRIMARY, pw(5'h10, 1'b0));
    chk_bit(fault, 1'b1);
    chk_bit(hold, 1'b0);
    wr(ADDR_PRIMARY, 24'h00_0100);
    rd(ADDR_PRIMARY, pw(5'h00, 1'b0));
    wr(ADDR_CFG1, 24'h00_0001);
    tick(1900);
    chk_bit(hiz, 1'b0);
    tick(200);
    chk_bit(fault, 1'b0);
    chk_bit(hiz, 1'b1);
    chk_bit(hold, 1'b0);
    rd(ADDR_PRIMARY, pw(5'h10, 1'b0));
    chk_bit(fault, 1'b1);
    chk_bit(hiz, 1'b0);
    chk_bit(miso_oe, 1'b0);
    close_out();
  end
endmodule
